// ---- shared/spd_loader_pkg.sv ----
// Purpose: Shared constants and types of the presence-detect loader
// Assumes: 40 MHz ref_clk
// Notes:   Serial clock kept at the 93.75 kHz figure, not at clk/256
package spd_loader_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ = 40_000_000;
   localparam int SCL_HZ = 93_750;
   localparam int SCL_CYC = (CLK_HZ + SCL_HZ - 1) / SCL_HZ;
   localparam int QTR_CYC = (SCL_CYC + 3) / 4;
   localparam logic [6:0] QTR_LAST = 7'(QTR_CYC - 1);
   localparam int PWR_WAIT_US = 200;
   localparam int PWR_WAIT_CYC = PWR_WAIT_US * (CLK_HZ / 1_000_000);
   localparam int TRC_NS = 70;
   localparam int TRC_CYC = (TRC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [1:0] TRC_LAST = 2'(TRC_CYC - 1);

   // ------------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------------
   localparam logic [31:0] CTRL_OFF = 32'h1000_0020;
   localparam logic [31:0] STAT_OFF = 32'h1000_0040;
   localparam logic [31:0] MASK_OFF = 32'h1000_0044;
   localparam logic [31:0] SHADOW_BASE = 32'h1000_0100;
   localparam int CAS_LSB = 0;
   localparam int SIZE_LSB = 2;
   localparam int READY_BIT = 5;
   localparam logic [1:0] CAS_RST = 2'h2;
   localparam logic [2:0] SIZE_RST = 3'h0;
   localparam int EV_SPD = 0;
   localparam int EV_INIT = 1;
   localparam int EV_NACK = 2;

   // ------------------------------------------------------------------
   // EEPROM and SDRAM figures
   // ------------------------------------------------------------------
   localparam logic [7:0] DEV_WR = 8'ha0;
   localparam logic [7:0] DEV_RD = 8'ha1;
   localparam logic [7:0] WORD_PTR = 8'h00;
   localparam logic [7:0] LAST_BYTE = 8'hff;
   localparam logic [5:0] LAST_WORD = 6'h3f;
   localparam logic [12:0] MODE_WORD = 13'h022;
   localparam logic [12:0] PRE_ALL = 13'h0400;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_MRS = 4'h0;

   // Byte engine commands
   typedef enum logic [3:0]
   {
      SC_START = 4'h1,
      SC_STOP = 4'h2,
      SC_WRITE = 4'h4,
      SC_READ = 4'h8
   } ser_cmd_t;

endpackage

// ---- logic/shadow_ram.sv ----
// Purpose: 64 x 32 shadow store of the presence-detect bytes
// Assumes: One write port, one read port
// Notes:   Read data registered, valid one cycle after the address
`timescale 1ns/1ps
module shadow_ram
(
   // Clock
   input wire logic ref_clk,
   // Write port
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [31:0] wdata,
   // Read port
   input wire logic [5:0] raddr,
   output logic [31:0] rdata
);

   logic [31:0] mem [0:63];

   // Write side
   always_ff @(posedge ref_clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read
   always_ff @(posedge ref_clk)
   begin
      rdata <= mem[raddr];
   end

endmodule // shadow_ram

// ---- logic/serial_byte_engine.sv ----
// Purpose: Two-wire start, stop and byte transfers for the EEPROM
// Assumes: Four quarter phases per serial bit
// Notes:   Data line open-drain; enable low while pulling low
`timescale 1ns/1ps
module serial_byte_engine
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Command side
   input wire logic go,
   input wire spd_loader_pkg::ser_cmd_t cmd,
   input wire logic [7:0] tx_byte,
   output logic ready,
   output logic done,
   output logic [7:0] rx_byte,
   output logic ack_ok,
   // Serial pins
   output logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);

   typedef enum logic [3:0]
   {
      E_IDLE = 4'b0001,
      E_START = 4'b0010,
      E_STOP = 4'b0100,
      E_BIT = 4'b1000
   } eng_state_t;

   eng_state_t state_r;
   logic [6:0] qcnt_r;
   logic [1:0] phase_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic is_read_r, samp_r, scl_r, pull_r;
   logic scl_nxt, pull_nxt;
   logic s1_r, s2_r, s3_r, sda_q_r;
   logic tick;

   assign tick = (qcnt_r == spd_loader_pkg::QTR_LAST);
   assign ready = (state_r == E_IDLE);
   assign scl = scl_r;
   assign sda_o = 1'b0;
   assign sda_oe_n = ~pull_r;

   // Three-stage input synchroniser, change taken when 2 and 3 agree
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
         s3_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         s1_r <= sda_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
         begin
            sda_q_r <= s3_r;
         end
      end
   end

   // Quarter-period timer, sets the serial bit rate
   always_ff @(posedge ref_clk)
   begin
      if (!nrst || state_r == E_IDLE)
      begin
         qcnt_r <= 7'h00;
         phase_r <= 2'h0;
      end
      else
      begin
         qcnt_r <= tick ? 7'h00 : qcnt_r + 7'h01;
         if (tick)
         begin
            phase_r <= phase_r + 2'h1;
         end
      end
   end

   // Sequencer: start, stop and nine-bit byte slots
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         state_r <= E_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         is_read_r <= 1'b0;
         samp_r <= 1'b1;
         done <= 1'b0;
         rx_byte <= 8'h00;
         ack_ok <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state_r)
            E_IDLE:
            begin
               if (go)
               begin
                  bit_r <= 4'h0;
                  sh_r <= tx_byte;
                  is_read_r <= (cmd == spd_loader_pkg::SC_READ);
                  case (cmd)
                     spd_loader_pkg::SC_START: state_r <= E_START;
                     spd_loader_pkg::SC_STOP: state_r <= E_STOP;
                     default: state_r <= E_BIT;
                  endcase
               end
            end
            E_START, E_STOP:
            begin
               if (tick && phase_r == 2'h3)
               begin
                  state_r <= E_IDLE;
                  done <= 1'b1;
               end
            end
            E_BIT:
            begin
               if (tick && phase_r == 2'h1)
               begin
                  samp_r <= sda_q_r;
               end
               if (tick && phase_r == 2'h3)
               begin
                  if (bit_r == 4'h8)
                  begin
                     ack_ok <= ~samp_r;
                     rx_byte <= sh_r;
                     state_r <= E_IDLE;
                     done <= 1'b1;
                  end
                  else
                  begin
                     sh_r <= {sh_r[6:0], samp_r};
                     bit_r <= bit_r + 4'h1;
                  end
               end
            end
            default: state_r <= E_IDLE;
         endcase
      end
   end

   // Pin levels per state and phase
   always_comb
   begin
      scl_nxt = scl_r;
      pull_nxt = pull_r;
      case (state_r)
         E_START:
         begin
            scl_nxt = (phase_r != 2'h3);
            pull_nxt = phase_r[1];
         end
         E_STOP:
         begin
            scl_nxt = (phase_r != 2'h0);
            pull_nxt = ~phase_r[1];
         end
         E_BIT:
         begin
            scl_nxt = (phase_r == 2'h1) || (phase_r == 2'h2);
            pull_nxt = (bit_r != 4'h8) && !is_read_r && !sh_r[7];
         end
         default:
         begin
            scl_nxt = scl_r;
            pull_nxt = pull_r;
         end
      endcase
   end

   // Registered pin drivers
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         scl_r <= 1'b1;
         pull_r <= 1'b0;
      end
      else
      begin
         scl_r <= scl_nxt;
         pull_r <= pull_nxt;
      end
   end

   // Cycles between serial clock rises, for checking only
   logic scl_d_r;
   logic [8:0] since_r;
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         scl_d_r <= 1'b1;
         since_r <= 9'h1ff;
      end
      else
      begin
         scl_d_r <= scl_r;
         if (scl_r && !scl_d_r)
            since_r <= 9'h001;
         else if (since_r != 9'h1ff)
            since_r <= since_r + 9'h001;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   scl_rate_a: assert property ($rose(scl_r) |->
      since_r >= 9'(spd_loader_pkg::SCL_CYC))
      else $error("serial clock faster than allowed");

   start_only_a: assert property ($rose(pull_r) && scl_r &&
      $past(scl_r) |-> $past(state_r) == E_START)
      else $error("data fell under high clock outside start");

endmodule // serial_byte_engine

// ---- logic/sdram_spd_power_up_loader.sv ----
// Purpose: Power-up SDRAM mode set and presence-detect shadow copy
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Shadow is read-only; EEPROM is only ever read
// Contract
// - Set SDRAM mode: burst four, latency two
// - Read all 256 bytes of EEPROM
// - Serial clock from divided reference clock
// - EEPROM reads stay under 100 kbit/s
// - Each byte framed by start and stop
// - Copy content into 64 x 32 shadow
// - Ready flag set once shadow is filled
// - Shadow words readable at random, no serial access
// - No writes to EEPROM, reads only
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module sdram_spd_power_up_loader
#(
   parameter int PWR_WAIT_CYC = spd_loader_pkg::PWR_WAIT_CYC
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Register port
   input wire logic [31:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rd_data,
   // Interrupt
   output logic irq,
   // SDRAM command pins
   output logic sd_cke,
   output logic sd_cs_n,
   output logic sd_ras_n,
   output logic sd_cas_n,
   output logic sd_we_n,
   output logic [1:0] sd_ba,
   output logic [12:0] sd_addr,
   // Settings for the SDRAM controller
   output logic [1:0] cas_latency,
   output logic [2:0] mem_size,
   output logic sd_init_done,
   // EEPROM link
   output logic spd_scl,
   input wire logic spd_sda_i,
   output logic spd_sda_o,
   output logic spd_sda_oe_n
);

   // ------------------------------------------------------------------
   // Types and state
   // ------------------------------------------------------------------
   typedef enum logic [4:0]
   {
      M_WAIT = 5'b00001,
      M_SDINIT = 5'b00010,
      M_PTR = 5'b00100,
      M_READ = 5'b01000,
      M_DONE = 5'b10000
   } main_state_t;

   main_state_t state_r;
   logic [15:0] wait_r;
   logic [2:0] sd_step_r;
   logic [1:0] gap_r;
   logic [3:0] sd_cmd_r;
   logic [12:0] sd_addr_r;
   logic [1:0] ser_step_r;
   logic [7:0] byte_r;
   logic [23:0] buf_r;
   logic mem_we_r;
   logic [5:0] mem_waddr_r;
   logic [31:0] mem_wdata_r;
   logic [31:0] mem_q;
   logic ready_r;
   logic [1:0] cas_r;
   logic [2:0] size_r;
   logic [2:0] status_r, mask_r, events;
   logic [31:0] rd_reg_r;
   logic rd_shadow_r;
   logic eng_go, eng_ready, eng_done, eng_ack;
   logic [7:0] eng_rx;
   spd_loader_pkg::ser_cmd_t cur_cmd;
   logic serial_on;

   // ------------------------------------------------------------------
   // Decoders
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [31:0] a,
                                input logic [31:0] off);
      hit = (a == off);
   endfunction

   function automatic spd_loader_pkg::ser_cmd_t cmd_of
      (input logic [1:0] step);
      case (step)
         2'h0: cmd_of = spd_loader_pkg::SC_START;
         2'h1: cmd_of = spd_loader_pkg::SC_WRITE;
         2'h2: cmd_of = spd_loader_pkg::SC_WRITE;
         default: cmd_of = spd_loader_pkg::SC_STOP;
      endcase
   endfunction

   function automatic logic [3:0] sd_cmd_of(input logic [2:0] step);
      case (step)
         3'h0: sd_cmd_of = spd_loader_pkg::CMD_PRE;
         3'h1: sd_cmd_of = spd_loader_pkg::CMD_REF;
         3'h2: sd_cmd_of = spd_loader_pkg::CMD_REF;
         default: sd_cmd_of = spd_loader_pkg::CMD_MRS;
      endcase
   endfunction

   // ------------------------------------------------------------------
   // Power-up sequence
   // ------------------------------------------------------------------
   // Wait, then precharge, two refreshes and the mode set
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         state_r <= M_WAIT;
         wait_r <= 16'h0000;
         sd_step_r <= 3'h0;
         gap_r <= 2'h0;
         sd_cmd_r <= spd_loader_pkg::CMD_NOP;
         sd_addr_r <= 13'h0000;
      end
      else
      begin
         sd_cmd_r <= spd_loader_pkg::CMD_NOP;
         case (state_r)
            M_WAIT:
            begin
               if (wait_r == 16'(PWR_WAIT_CYC - 1))
                  state_r <= M_SDINIT;
               else
                  wait_r <= wait_r + 16'h0001;
            end
            M_SDINIT:
            begin
               if (gap_r != 2'h0)
                  gap_r <= gap_r - 2'h1;
               else if (sd_step_r == 3'h4)
                  state_r <= M_PTR;
               else
               begin
                  sd_cmd_r <= sd_cmd_of(sd_step_r);
                  sd_addr_r <= (sd_step_r == 3'h0) ?
                     spd_loader_pkg::PRE_ALL :
                     spd_loader_pkg::MODE_WORD;
                  gap_r <= spd_loader_pkg::TRC_LAST;
                  sd_step_r <= sd_step_r + 3'h1;
               end
            end
            M_PTR:
            begin
               if (eng_done && ser_step_r == 2'h3)
                  state_r <= M_READ;
            end
            M_READ:
            begin
               if (eng_done && ser_step_r == 2'h3 &&
                   byte_r == spd_loader_pkg::LAST_BYTE)
                  state_r <= M_DONE;
            end
            M_DONE: state_r <= M_DONE;
            default: state_r <= M_WAIT;
         endcase
      end
   end

   assign sd_cke = 1'b1;
   assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = sd_cmd_r;
   assign sd_ba = 2'h0;
   assign sd_addr = sd_addr_r;
   assign sd_init_done = (state_r != M_WAIT) && (state_r != M_SDINIT);

   // ------------------------------------------------------------------
   // Serial read walk
   // ------------------------------------------------------------------
   assign serial_on = (state_r == M_PTR) || (state_r == M_READ);
   assign cur_cmd = (state_r == M_READ && ser_step_r == 2'h2) ?
      spd_loader_pkg::SC_READ : cmd_of(ser_step_r);
   assign eng_go = serial_on && eng_ready && !eng_done;

   // Step through start, address, data, stop for every byte
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         ser_step_r <= 2'h0;
         byte_r <= 8'h00;
      end
      else if (serial_on && eng_done)
      begin
         ser_step_r <= ser_step_r + 2'h1;
         if (state_r == M_READ && ser_step_r == 2'h3)
            byte_r <= byte_r + 8'h01;
      end
   end

   // Address byte: pointer set only by a word-address dummy, no data
   logic [7:0] tx_byte;
   always_comb
   begin
      tx_byte = spd_loader_pkg::DEV_RD;
      if (state_r == M_PTR)
         tx_byte = (ser_step_r == 2'h1) ? spd_loader_pkg::DEV_WR :
                   spd_loader_pkg::WORD_PTR;
   end

   serial_byte_engine u_eng
   (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .go(eng_go),
      .cmd(cur_cmd),
      .tx_byte(tx_byte),
      .ready(eng_ready),
      .done(eng_done),
      .rx_byte(eng_rx),
      .ack_ok(eng_ack),
      .scl(spd_scl),
      .sda_i(spd_sda_i),
      .sda_o(spd_sda_o),
      .sda_oe_n(spd_sda_oe_n)
   );

   // ------------------------------------------------------------------
   // Shadow fill
   // ------------------------------------------------------------------
   // Pack four bytes, lowest address in bits 7:0, then write a word
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         buf_r <= 24'h000000;
         mem_we_r <= 1'b0;
         mem_waddr_r <= 6'h00;
         mem_wdata_r <= 32'h0000_0000;
      end
      else
      begin
         mem_we_r <= 1'b0;
         if (state_r == M_READ && eng_done && ser_step_r == 2'h2)
         begin
            buf_r <= {eng_rx, buf_r[23:8]};
            if (byte_r[1:0] == 2'h3)
            begin
               mem_we_r <= 1'b1;
               mem_waddr_r <= byte_r[7:2];
               mem_wdata_r <= {eng_rx, buf_r};
            end
         end
      end
   end

   shadow_ram u_ram
   (
      .ref_clk(ref_clk),
      .we(mem_we_r),
      .waddr(mem_waddr_r),
      .wdata(mem_wdata_r),
      .raddr(addr[7:2]),
      .rdata(mem_q)
   );

   // Ready flag rises with the last word write and stays
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
         ready_r <= 1'b0;
      else if (mem_we_r && mem_waddr_r == spd_loader_pkg::LAST_WORD)
         ready_r <= 1'b1;
   end

   // ------------------------------------------------------------------
   // Registers and interrupt
   // ------------------------------------------------------------------
   assign events[spd_loader_pkg::EV_SPD] = mem_we_r &&
      mem_waddr_r == spd_loader_pkg::LAST_WORD;
   assign events[spd_loader_pkg::EV_INIT] = (state_r == M_SDINIT) &&
      gap_r == 2'h0 && sd_step_r == 3'h4;
   assign events[spd_loader_pkg::EV_NACK] = serial_on && eng_done &&
      cur_cmd == spd_loader_pkg::SC_WRITE && !eng_ack;

   // Control fields, mask, and sticky status with set over clear
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         cas_r <= spd_loader_pkg::CAS_RST;
         size_r <= spd_loader_pkg::SIZE_RST;
         mask_r <= 3'h0;
         status_r <= 3'h0;
      end
      else
      begin
         if (wr_en && hit(addr, spd_loader_pkg::CTRL_OFF))
         begin
            cas_r <= wr_data[spd_loader_pkg::CAS_LSB +: 2];
            size_r <= wr_data[spd_loader_pkg::SIZE_LSB +: 3];
         end
         if (wr_en && hit(addr, spd_loader_pkg::MASK_OFF))
            mask_r <= wr_data[2:0];
         status_r <= (status_r &
            ~((wr_en && hit(addr, spd_loader_pkg::STAT_OFF)) ?
            wr_data[2:0] : 3'h0)) | events;
      end
   end

   assign cas_latency = cas_r;
   assign mem_size = size_r;
   assign irq = |(status_r & mask_r);

   // Read data, valid only the cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         rd_reg_r <= 32'h0000_0000;
         rd_shadow_r <= 1'b0;
      end
      else
      begin
         rd_reg_r <= 32'h0000_0000;
         rd_shadow_r <= rd_en && addr[31:8] ==
            spd_loader_pkg::SHADOW_BASE[31:8] && addr[1:0] == 2'h0;
         if (rd_en && hit(addr, spd_loader_pkg::CTRL_OFF))
         begin
            rd_reg_r[spd_loader_pkg::CAS_LSB +: 2] <= cas_r;
            rd_reg_r[spd_loader_pkg::SIZE_LSB +: 3] <= size_r;
            rd_reg_r[spd_loader_pkg::READY_BIT] <= ready_r;
         end
         if (rd_en && hit(addr, spd_loader_pkg::STAT_OFF))
            rd_reg_r[2:0] <= status_r;
         if (rd_en && hit(addr, spd_loader_pkg::MASK_OFF))
            rd_reg_r[2:0] <= mask_r;
      end
   end

   assign rd_data = rd_shadow_r ? mem_q : rd_reg_r;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   sequence mode_set_s;
      sd_cmd_r == spd_loader_pkg::CMD_MRS ##1
      (sd_cmd_r == spd_loader_pkg::CMD_NOP) [*3];
   endsequence

   mode_word_a: assert property (sd_cmd_r ==
      spd_loader_pkg::CMD_MRS |-> sd_addr_r == 13'h022)
      else $error("mode word not burst four latency two");

   mode_then_link_a: assert property (mode_set_s |->
      ##[0:2] state_r == M_PTR)
      else $error("serial copy not started after mode set");

   ready_cause_a: assert property ($rose(ready_r) |->
      $past(mem_we_r) && $past(mem_waddr_r) == 6'h3f)
      else $error("ready flag rose without last word");

   ready_stays_a: assert property (ready_r |=> ready_r)
      else $error("ready flag dropped");

   ready_read_a: assert property (rd_en &&
      addr == 32'h1000_0020 |=> rd_data[5] == $past(ready_r))
      else $error("ready bit not seen in control read");

   ready_event_a: assert property ($rose(ready_r) |->
      status_r[0])
      else $error("ready event not latched");

   read_only_a: assert property (eng_go && state_r == M_READ &&
      cur_cmd == spd_loader_pkg::SC_WRITE |-> tx_byte == 8'ha1)
      else $error("write address sent during copy");

   stop_after_a: assert property (state_r == M_READ && eng_done &&
      ser_step_r == 2'h2 |=> cur_cmd == spd_loader_pkg::SC_STOP)
      else $error("data byte not followed by stop");

   all_bytes_a: assert property ($rose(state_r == M_DONE) |->
      $past(byte_r) == 8'hff)
      else $error("copy ended before last byte");

endmodule // sdram_spd_power_up_loader

// ---- verif/spd_eeprom_model.sv ----
// Purpose: Behavioural presence-detect EEPROM on the two-wire link
// Assumes: Data line has a pull-up; pull high means driving it low
// Notes:   Logs the first bytes the master sends, acks every one
`timescale 1ns/1ps
module spd_eeprom_model
(
   // Serial link
   input wire logic scl,
   input wire logic sda,
   output logic pull
);
   // ---------------------------------------------------------------
   // Frame tracking
   // ---------------------------------------------------------------
   logic [7:0] sh = 8'h00;
   logic [7:0] dat = 8'h5a;
   logic [7:0] got [0:15];
   logic rd = 1'b0;
   int bits = 0;
   int frm = 0;
   int nb = 0;
   int starts = 0;
   int stops = 0;
   initial pull = 1'b0;
   // Start and stop are data edges while the clock is high
   always @(sda)
   begin
      if (scl === 1'b1 && sda === 1'b0)
      begin
         starts++;
         bits = 0;
         frm = 0;
         rd = 1'b0;
      end
      else if (scl === 1'b1 && starts > stops) // Skip the reset edge
         stops++;
   end
   // Shift in on the rising clock edge
   always @(posedge scl)
   begin
      if (bits < 8)
         sh = {sh[6:0], sda};
      bits++;
   end
   // Ack or data bits change only while the clock is low
   always @(negedge scl)
   begin
      if (bits == 8 && (frm == 0 || !rd))
      begin
         if (nb < 16)
            got[nb] = sh;
         nb++;
         rd = (frm == 0) ? sh[0] : rd;
         pull = 1'b1;
      end
      else if (bits == 9)
      begin
         bits = 0;
         if (rd && frm > 0)
            dat = dat + 8'h01;
         pull = rd && frm == 0 && !dat[7];
         frm++;
      end
      else if (rd && frm > 0 && bits < 8)
         pull = !dat[7 - bits];
      else
         pull = 1'b0;
   end
endmodule // spd_eeprom_model

// ---- verif/sdram_spd_power_up_loader_tb_top.sv ----
// Purpose: Self-checking bench of the power-up loader
// Assumes: 40 MHz ref_clk, short power wait of 20 cycles
// Notes:   Full copy is too long to run; early link traffic is judged
`timescale 1ns/1ps
module sdram_spd_power_up_loader_tb_top;
   // ---------------------------------------------------------------
   // Bench signals
   // ---------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rd_data;
   logic irq, sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_init_done;
   logic [1:0] sd_ba;
   logic [12:0] sd_addr;
   logic [1:0] cas_latency;
   logic [2:0] mem_size;
   logic spd_scl, spd_sda_o, spd_sda_oe_n, pull;
   wire sda = !(!spd_sda_oe_n && !spd_sda_o) && !pull;
   logic [3:0] cmd_q [$];
   logic [12:0] adr_q [$];
   int cyc_q [$];
   int cyc = 0;
   int n_fail = 0;
   int checks_done = 0;
   always #12.5 ref_clk = !ref_clk;
   sdram_spd_power_up_loader #(.PWR_WAIT_CYC(20)) dut (.ref_clk, .nrst,
      .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq, .sd_cke, .sd_cs_n,
      .sd_ras_n, .sd_cas_n, .sd_we_n, .sd_ba, .sd_addr, .cas_latency,
      .mem_size, .sd_init_done, .spd_scl, .spd_sda_i(sda), .spd_sda_o,
      .spd_sda_oe_n);
   spd_eeprom_model mdl (.scl(spd_scl), .sda(sda), .pull(pull));
   // Log every SDRAM command other than no-op
   always @(posedge ref_clk)
   begin
      cyc++;
      if (nrst && {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} !== 4'h7)
      begin
         cmd_q.push_back({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n});
         adr_q.push_back(sd_addr);
         cyc_q.push_back(cyc);
      end
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Register bus cycles
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask
   task automatic rchk(input logic [31:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 chk(rd_data, e);
   endtask
   // Control reset value, field write, read-only flag, unmapped read
   task automatic t_regs;
      rchk(spd_loader_pkg::CTRL_OFF, 32'h02);
      wr(spd_loader_pkg::CTRL_OFF, 32'h3f);
      rchk(spd_loader_pkg::CTRL_OFF, 32'h1f);
      chk(32'(cas_latency), 32'h3);
      chk(32'(mem_size), 32'h7);
      rchk(32'h1000_0030, 32'h0);
   endtask
   // Power-up command order and mode word
   task automatic t_sdram;
      logic [3:0] ec [4] = '{4'h2, 4'h1, 4'h1, 4'h0};
      repeat (300) if (sd_init_done !== 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      chk(32'(cmd_q.size()), 32'h4);
      for (int i = 0; i < 4; i++)
         chk(32'(cmd_q[i]), 32'(ec[i]));
      for (int i = 1; i < 4; i++)
         chk(32'(cyc_q[i] - cyc_q[i - 1]),
             32'(spd_loader_pkg::TRC_CYC));
      chk(32'(adr_q[0]), 32'h400);
      chk(32'(adr_q[3]), (32'h2 << 4) | 32'h2);
      chk({29'h0, sd_cke, sd_ba}, 32'h4);
   endtask
   // Sticky status, mask and level interrupt
   task automatic t_irq;
      rchk(spd_loader_pkg::STAT_OFF, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(spd_loader_pkg::MASK_OFF, 32'h2);
      rchk(spd_loader_pkg::MASK_OFF, 32'h2);
      chk({31'h0, irq}, 32'h1);
      wr(spd_loader_pkg::STAT_OFF, 32'h2);
      rchk(spd_loader_pkg::STAT_OFF, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask
   // Serial clock rate, framing and read-only traffic
   task automatic t_link;
      realtime t0;
      int per;
      repeat (20000) if (mdl.starts < 1) @(posedge ref_clk);
      @(posedge spd_scl);
      t0 = $realtime;
      @(posedge spd_scl);
      per = int'(($realtime - t0) / 25.0);
      chk(32'(per), 32'(4 * spd_loader_pkg::QTR_CYC));
      chk({31'h0, per >= 400}, 32'h1);
      repeat (40000) if (mdl.stops < 3) @(posedge ref_clk);
      chk(32'(mdl.stops), 32'h3);
      chk(32'(mdl.starts), 32'(mdl.stops));
      chk({24'h0, mdl.got[0]}, 32'(spd_loader_pkg::DEV_WR));
      chk({24'h0, mdl.got[1]}, 32'(spd_loader_pkg::WORD_PTR));
      chk({24'h0, mdl.got[2]}, 32'(spd_loader_pkg::DEV_RD));
      chk({24'h0, mdl.got[3]}, 32'(spd_loader_pkg::DEV_RD));
      rchk(spd_loader_pkg::CTRL_OFF, 32'h1f);
   endtask
   // Verdict and end of run
   task automatic wrap_up;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs();
      t_sdram();
      t_irq();
      t_link();
      wrap_up();
   end
   // Watchdog
   initial
   begin
      #1_750_000;
      n_fail++;
      wrap_up();
   end
endmodule // sdram_spd_power_up_loader_tb_top
